// File: logic/sgds_engine.sv
// Scatter-gather descriptor engine of the memory-to-stream channel
`timescale 1ns/1ps
// How it works
// R1: Byte count goes in status bits 22..0.
// R2: Count uses only length-width bits, 8 MB.
// R3: Clean finish reports count equal buffer length.
// R4: Zero buffer length sets internal error bit 28.
// R5: Errors clear run/stop; halted after full stop.
// R6: Slave error response sets bit 29, halts.
// R7: Decode error response sets bit 30, halts.
// R8: Finished transfer sets completion bit 31.
// R9: Software reuses descriptors only once completed.
// R10: Fetched completed descriptor is stale: SG error.
// R11: Option on: send start-of-frame user words.
// R12: Option on: fetch other user words, discard.
// R13: Option off: user words are never fetched.
// R14: Stream-to-memory next pointer uses bits 31..6.
// R15: Descriptors sit on 0x40 boundaries.
// R16: Software writes zero in status bits 27..23.
// R17: Software marks first buffer with bit 27.
// R18: Flags and completion written in one update.
module sgds_engine
  import sgds_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic run_start,
  input wire logic tail_kick,
  input wire logic [31:0] first_desc_ptr,
  input wire logic [31:0] tail_desc_ptr,
  input wire logic ctrl_stream_option,
  output logic run_stop_bit,
  output logic halted_status_bit,
  output logic idle,
  output logic internal_error_flag,
  output logic slave_error_flag,
  output logic decode_error_flag,
  output logic sg_internal_error,
  output logic mem_cmd_valid,
  input wire logic mem_cmd_ready,
  output sgds_mem_cmd_type mem_cmd,
  input wire logic mem_rsp_valid,
  input wire sgds_mem_rsp_type mem_rsp,
  output logic m_tvalid,
  input wire logic m_tready,
  output sgds_beat_type m_beat,
  output logic [31:0] ctrl_tdata,
  output logic ctrl_tvalid,
  output logic ctrl_tlast,
  input wire logic ctrl_tready,
  input wire logic [31:0] stream_to_mem_channel_ptr_word,
  output logic [31:0] stream_to_mem_channel_next_desc
);

  ////////////////////////////////////////////////////////////////////////
  function automatic sgds_mem_cmd_type rd_cmd(input logic [31:0] addr);
    sgds_mem_cmd_type c;
    c.write = 1'b0;
    c.addr = addr;
    c.wdata = ZERO_WORD;
    return c;
  endfunction

  function automatic logic [3:0] keep_of(input logic [22:0] left);
    logic [3:0] k;
    k = 4'hf;
    if (left < BYTES_PER_WORD)
      k = 4'hf >> (3'h4 - left[2:0]);
    return k;
  endfunction

  function automatic logic [22:0] len_of(input logic [31:0] ctrl);
    logic [22:0] l;
    l = ZERO_COUNT;
    l[LEN_WIDTH-1:0] = ctrl[LEN_WIDTH-1:0]; // R2
    return l;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  sgds_state_type state_reg, state_next;
  sgds_mem_cmd_type cmd_reg, cmd_next;
  sgds_beat_type beat_reg, beat_next;
  sgds_err_type err_reg, err_next;
  sgds_app_words_type app_reg, app_next;
  logic [31:0] desc_reg, desc_next;
  logic [31:0] nxt_reg, nxt_next;
  logic [31:0] buf_reg, buf_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] addr_reg, addr_next;
  logic [31:0] stream_to_mem_channel_reg, stream_to_mem_channel_next;
  logic [22:0] left_reg, left_next;
  logic [22:0] moved_reg, moved_next;
  logic [3:0] idx_reg, idx_next;
  logic run_reg, run_next;
  logic halted_reg, halted_next;
  logic sg_err_reg, sg_err_next;
  logic ctrl_load;
  logic ctrl_busy;
  logic [3:0] last_idx;
  logic [31:0] ctrl_word;
  logic [22:0] beat_bytes;
  logic [31:0] fetch_addr;

  // Option off stops the fetch at the status word
  assign last_idx = ctrl_stream_option ? WORD_APP_LAST : WORD_STATUS; // R13
  assign fetch_addr = desc_reg + {26'h0, idx_reg + 4'h1, 2'h0};
  assign beat_bytes = (left_reg < BYTES_PER_WORD) ? left_reg
                                                  : BYTES_PER_WORD;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    beat_next = beat_reg;
    err_next = err_reg;
    app_next = app_reg;
    desc_next = desc_reg;
    nxt_next = nxt_reg;
    buf_next = buf_reg;
    ctrl_next = ctrl_reg;
    addr_next = addr_reg;
    left_next = left_reg;
    moved_next = moved_reg;
    idx_next = idx_reg;
    run_next = run_reg;
    halted_next = halted_reg;
    sg_err_next = sg_err_reg;
    ctrl_load = 1'b0;
    ctrl_word = ctrl_reg;
    stream_to_mem_channel_next = stream_to_mem_channel_ptr_word & DESC_ALIGN_MASK; // R14
    case (state_reg)
      ST_IDLE, ST_HALTED:
      begin
        if (run_start)
        begin
          // Low pointer bits are ignored since descriptors are aligned
          desc_next = first_desc_ptr & DESC_ALIGN_MASK; // R15
          run_next = 1'b1;
          halted_next = 1'b0;
          err_next = '0;
          sg_err_next = 1'b0;
          idx_next = ZERO_IDX;
          cmd_next = rd_cmd((first_desc_ptr & DESC_ALIGN_MASK));
          state_next = ST_FETCH_REQ;
        end
        else if (state_reg == ST_IDLE && run_reg && tail_kick)
        begin
          desc_next = nxt_reg & DESC_ALIGN_MASK;
          idx_next = ZERO_IDX;
          cmd_next = rd_cmd((nxt_reg & DESC_ALIGN_MASK));
          state_next = ST_FETCH_REQ;
        end
      end
      ST_FETCH_REQ:
      begin
        if (mem_cmd_ready)
          state_next = ST_FETCH_RSP;
      end
      ST_FETCH_RSP:
      begin
        if (mem_rsp_valid)
        begin
          if (mem_rsp.resp != RESP_OKAY)
          begin
            sg_err_next = 1'b1;
            run_next = 1'b0; // R5
            state_next = ST_HALT_WAIT;
          end
          else if (idx_reg == WORD_STATUS && mem_rsp.rdata[ST_CMPLT_BIT])
          begin
            // Stale descriptor: no write-back, the word is left alone
            sg_err_next = 1'b1; // R10
            run_next = 1'b0; // R5
            state_next = ST_HALT_WAIT;
          end
          else
          begin
            if (idx_reg == WORD_NEXT)
              nxt_next = mem_rsp.rdata;
            if (idx_reg == WORD_BUF)
              buf_next = mem_rsp.rdata;
            if (idx_reg == WORD_CTRL)
            begin
              ctrl_next = mem_rsp.rdata;
              ctrl_word = mem_rsp.rdata;
            end
            if (idx_reg >= WORD_APP0 && ctrl_reg[CTRL_SOF_BIT])
              app_next[idx_reg[2:0]] = mem_rsp.rdata; // R12
            if (idx_reg == last_idx)
            begin
              left_next = len_of(ctrl_word);
              moved_next = ZERO_COUNT;
              addr_next = buf_reg;
              if (len_of(ctrl_word) == ZERO_COUNT)
              begin
                err_next.internal = 1'b1; // R4
                run_next = 1'b0; // R5
                state_next = ST_WB_REQ;
              end
              else if (ctrl_stream_option && ctrl_word[CTRL_SOF_BIT])
                state_next = ST_CTRL_WAIT; // R11
              else
              begin
                cmd_next = rd_cmd(buf_reg);
                state_next = ST_DATA_REQ;
              end
            end
            else
            begin
              idx_next = idx_reg + 4'h1;
              cmd_next = rd_cmd(fetch_addr);
              state_next = ST_FETCH_REQ;
            end
          end
        end
      end
      ST_CTRL_WAIT:
      begin
        // The previous packet's words must leave before these load
        if (!ctrl_busy)
        begin
          ctrl_load = 1'b1; // R11
          cmd_next = rd_cmd(addr_reg);
          state_next = ST_DATA_REQ;
        end
      end
      ST_DATA_REQ:
      begin
        if (mem_cmd_ready)
          state_next = ST_DATA_RSP;
      end
      ST_DATA_RSP:
      begin
        if (mem_rsp_valid)
        begin
          if (mem_rsp.resp == RESP_SLVERR)
          begin
            err_next.slave = 1'b1; // R6
            run_next = 1'b0; // R5
            state_next = ST_WB_REQ;
          end
          else if (mem_rsp.resp == RESP_DECERR)
          begin
            err_next.decode = 1'b1; // R7
            run_next = 1'b0; // R5
            state_next = ST_WB_REQ;
          end
          else
          begin
            beat_next.data = mem_rsp.rdata;
            beat_next.keep = keep_of(left_reg);
            beat_next.last = ctrl_reg[CTRL_EOF_BIT] &&
                             (left_reg <= BYTES_PER_WORD);
            state_next = ST_DATA_OUT;
          end
        end
      end
      ST_DATA_OUT:
      begin
        if (m_tready)
        begin
          moved_next = moved_reg + beat_bytes; // R1 R3
          left_next = left_reg - beat_bytes;
          addr_next = addr_reg + 32'h4;
          if (left_reg == beat_bytes)
            state_next = ST_WB_REQ;
          else
          begin
            cmd_next = rd_cmd(addr_reg + 32'h4);
            state_next = ST_DATA_REQ;
          end
        end
      end
      ST_WB_REQ:
      begin
        // One write carries count, error flags and completion together
        cmd_next.write = 1'b1; // R18
        cmd_next.addr = desc_reg + {26'h0, WORD_STATUS, 2'h0};
        cmd_next.wdata = ZERO_WORD;
        cmd_next.wdata[LEN_FIELD_WIDTH-1:0] = moved_reg; // R1
        cmd_next.wdata[ST_INT_ERR_BIT] = err_reg.internal; // R4
        cmd_next.wdata[ST_SLV_ERR_BIT] = err_reg.slave; // R6
        cmd_next.wdata[ST_DEC_ERR_BIT] = err_reg.decode; // R7
        cmd_next.wdata[ST_CMPLT_BIT] = (err_reg == '0); // R8
        if (mem_cmd_valid && mem_cmd_ready)
          state_next = ST_WB_RSP;
      end
      ST_WB_RSP:
      begin
        if (mem_rsp_valid)
        begin
          if (err_reg != '0 || mem_rsp.resp != RESP_OKAY)
          begin
            if (mem_rsp.resp != RESP_OKAY)
              sg_err_next = 1'b1;
            run_next = 1'b0; // R5
            state_next = ST_HALT_WAIT;
          end
          else if (desc_reg == (tail_desc_ptr & DESC_ALIGN_MASK))
            state_next = ST_IDLE;
          else
          begin
            desc_next = nxt_reg & DESC_ALIGN_MASK;
            idx_next = ZERO_IDX;
            cmd_next = rd_cmd((nxt_reg & DESC_ALIGN_MASK));
            state_next = ST_FETCH_REQ;
          end
        end
      end
      ST_HALT_WAIT:
      begin
        // Halted only once the control stream has drained too
        if (!ctrl_busy)
        begin
          halted_next = 1'b1; // R5
          state_next = ST_HALTED;
        end
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_IDLE;
      cmd_reg <= '0;
      beat_reg <= '0;
      err_reg <= '0;
      app_reg <= '0;
      desc_reg <= ZERO_WORD;
      nxt_reg <= ZERO_WORD;
      buf_reg <= ZERO_WORD;
      ctrl_reg <= ZERO_WORD;
      addr_reg <= ZERO_WORD;
      stream_to_mem_channel_reg <= ZERO_WORD;
      left_reg <= ZERO_COUNT;
      moved_reg <= ZERO_COUNT;
      idx_reg <= ZERO_IDX;
      run_reg <= 1'b0;
      halted_reg <= 1'b1;
      sg_err_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      beat_reg <= beat_next;
      err_reg <= err_next;
      app_reg <= app_next;
      desc_reg <= desc_next;
      nxt_reg <= nxt_next;
      buf_reg <= buf_next;
      ctrl_reg <= ctrl_next;
      addr_reg <= addr_next;
      stream_to_mem_channel_reg <= stream_to_mem_channel_next;
      left_reg <= left_next;
      moved_reg <= moved_next;
      idx_reg <= idx_next;
      run_reg <= run_next;
      halted_reg <= halted_next;
      sg_err_reg <= sg_err_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  sgds_ctrl_tx u_ctrl_tx (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .load(ctrl_load),
    .words(app_reg),
    .busy(ctrl_busy),
    .ctrl_tdata(ctrl_tdata),
    .ctrl_tvalid(ctrl_tvalid),
    .ctrl_tlast(ctrl_tlast),
    .ctrl_tready(ctrl_tready)
  );

  // Write-back command is built during the first cycle of ST_WB_REQ
  assign mem_cmd_valid = (state_reg == ST_FETCH_REQ) ||
                         (state_reg == ST_DATA_REQ) ||
                         (state_reg == ST_WB_REQ && cmd_reg.write);
  assign mem_cmd = cmd_reg;
  assign m_tvalid = (state_reg == ST_DATA_OUT);
  assign m_beat = beat_reg;
  assign run_stop_bit = run_reg;
  assign halted_status_bit = halted_reg;
  assign idle = (state_reg == ST_IDLE);
  assign internal_error_flag = err_reg.internal;
  assign slave_error_flag = err_reg.slave;
  assign decode_error_flag = err_reg.decode;
  assign sg_internal_error = sg_err_reg;
  assign stream_to_mem_channel_next_desc = stream_to_mem_channel_reg;

endmodule

// File: logic/sgds_pkg.sv
// Constants and carrier types shared by the descriptor engine files
package sgds_pkg;

  // Descriptor word layout, as word indices from the descriptor base
  localparam logic [3:0] WORD_NEXT = 4'h0;
  localparam logic [3:0] WORD_BUF = 4'h2;
  localparam logic [3:0] WORD_CTRL = 4'h6;
  localparam logic [3:0] WORD_STATUS = 4'h7;
  localparam logic [3:0] WORD_APP0 = 4'h8;
  localparam logic [3:0] WORD_APP_LAST = 4'hc;
  localparam int NUM_APP = 5;

  // Field positions
  localparam int LEN_FIELD_WIDTH = 23;
  localparam int LEN_WIDTH = 23;
  localparam int CTRL_EOF_BIT = 26;
  localparam int CTRL_SOF_BIT = 27;
  localparam int ST_INT_ERR_BIT = 28;
  localparam int ST_SLV_ERR_BIT = 29;
  localparam int ST_DEC_ERR_BIT = 30;
  localparam int ST_CMPLT_BIT = 31;
  localparam logic [31:0] DESC_ALIGN_MASK = 32'hffff_ffc0;

  // Memory response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Bytes per data word and reset values
  localparam logic [22:0] BYTES_PER_WORD = 23'h000004;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [22:0] ZERO_COUNT = 23'h000000;
  localparam logic [3:0] ZERO_IDX = 4'h0;
  localparam logic [2:0] ZERO_APP_IDX = 3'h0;
  localparam logic [2:0] APP_LAST_IDX = 3'h4;

  typedef struct packed {
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sgds_mem_cmd_type;

  typedef struct packed {
    logic [31:0] rdata;
    logic [1:0] resp;
  } sgds_mem_rsp_type;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0] keep;
    logic last;
  } sgds_beat_type;

  typedef struct packed {
    logic decode;
    logic slave;
    logic internal;
  } sgds_err_type;

  typedef logic [NUM_APP-1:0][31:0] sgds_app_words_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_FETCH_REQ = 4'h1,
    ST_FETCH_RSP = 4'h2,
    ST_CTRL_WAIT = 4'h3,
    ST_DATA_REQ = 4'h4,
    ST_DATA_RSP = 4'h5,
    ST_DATA_OUT = 4'h6,
    ST_WB_REQ = 4'h7,
    ST_WB_RSP = 4'h8,
    ST_HALT_WAIT = 4'h9,
    ST_HALTED = 4'ha
  } sgds_state_type;

endpackage

// File: logic/sgds_ctrl_tx.sv
// Control stream sender for the user application words of a packet
`timescale 1ns/1ps
module sgds_ctrl_tx
  import sgds_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic load,
  input wire sgds_app_words_type words,
  output logic busy,
  output logic [31:0] ctrl_tdata,
  output logic ctrl_tvalid,
  output logic ctrl_tlast,
  input wire logic ctrl_tready
);

  sgds_app_words_type words_reg;
  sgds_app_words_type words_next;
  logic [2:0] idx_reg;
  logic [2:0] idx_next;
  logic busy_reg;
  logic busy_next;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    words_next = words_reg;
    idx_next = idx_reg;
    busy_next = busy_reg;
    // Loads are only issued while idle, so a packet is never overwritten
    if (!busy_reg && load)
    begin
      words_next = words;
      idx_next = ZERO_APP_IDX;
      busy_next = 1'b1;
    end
    else if (busy_reg && ctrl_tready)
    begin
      if (idx_reg == APP_LAST_IDX)
        busy_next = 1'b0;
      else
        idx_next = idx_reg + 3'h1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      words_reg <= '0;
      idx_reg <= ZERO_APP_IDX;
      busy_reg <= 1'b0;
    end
    else
    begin
      words_reg <= words_next;
      idx_reg <= idx_next;
      busy_reg <= busy_next;
    end
  end

  assign busy = busy_reg;
  assign ctrl_tvalid = busy_reg;
  assign ctrl_tdata = words_reg[idx_reg];
  assign ctrl_tlast = busy_reg && (idx_reg == APP_LAST_IDX);

endmodule

// File: tb/sgds_chk_monitor.sv
// Checker of the descriptor engine port behaviour
`timescale 1ns/1ps
module sgds_chk_monitor
  import sgds_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic run_stop_bit,
  input wire logic halted_status_bit,
  input wire logic internal_error_flag,
  input wire logic slave_error_flag,
  input wire logic decode_error_flag,
  input wire logic sg_internal_error,
  input wire logic mem_cmd_valid,
  input wire logic mem_cmd_ready,
  input wire sgds_mem_cmd_type mem_cmd,
  input wire logic m_tvalid,
  input wire logic m_tready,
  input wire sgds_beat_type m_beat,
  input wire logic [31:0] ctrl_tdata,
  input wire logic ctrl_tvalid,
  input wire logic ctrl_tlast,
  input wire logic ctrl_tready,
  input wire logic [31:0] stream_to_mem_channel_ptr_word,
  input wire logic [31:0] stream_to_mem_channel_next_desc
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [2:0] beat_cnt_reg;
  logic [2:0] beat_cnt_next;
  logic any_err;
  assign any_err = internal_error_flag | slave_error_flag
    | decode_error_flag | sg_internal_error;
  // Control beats seen so far in the current packet
  always_comb
  begin
    beat_cnt_next = beat_cnt_reg;
    if (ctrl_tvalid && ctrl_tready)
      beat_cnt_next = ctrl_tlast ? 3'h0 : beat_cnt_reg + 3'h1;
  end
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      beat_cnt_reg <= 3'h0;
    else
      beat_cnt_reg <= beat_cnt_next;
  end
  //////////////////////////////////////////////////////////////////////////////
  cmd_hold_a: assert property (
    mem_cmd_valid && !mem_cmd_ready |=> mem_cmd_valid && $stable(mem_cmd))
    else $error("memory command dropped before taken");
  beat_hold_a: assert property (
    m_tvalid && !m_tready |=> m_tvalid && $stable(m_beat))
    else $error("data beat dropped before taken");
  ctrl_hold_a: assert property (
    ctrl_tvalid && !ctrl_tready |=> ctrl_tvalid && $stable(ctrl_tdata))
    else $error("control beat dropped before taken");
  ctrl_last_a: assert property (
    ctrl_tvalid && ctrl_tready && ctrl_tlast |-> beat_cnt_reg == 3'h4)
    else $error("control packet not five words");
  err_stop_a: assert property (
    any_err |-> !run_stop_bit)
    else $error("run bit set while error flagged");
  err_halt_a: assert property (
    $rose(any_err) |-> ##[0:300] halted_status_bit)
    else $error("no halt after error");
  halt_quiet_a: assert property (
    halted_status_bit |-> !mem_cmd_valid && !m_tvalid && !ctrl_tvalid)
    else $error("activity while halted");
  ptr_mask_a: assert property (
    1'b1 |=> stream_to_mem_channel_next_desc == ($past(stream_to_mem_channel_ptr_word) & 32'hffff_ffc0))
    else $error("next pointer masking wrong");
  wb_cmplt_a: assert property (
    mem_cmd_valid && mem_cmd.write |-> mem_cmd.wdata[27:23] == 5'h00
      && mem_cmd.wdata[31] == !(|mem_cmd.wdata[30:28]))
    else $error("status word flags inconsistent");
  wb_addr_a: assert property (
    mem_cmd_valid && mem_cmd.write |-> mem_cmd.addr[5:0] == 6'h1c)
    else $error("write not to status word");
endmodule

bind sgds_engine sgds_chk_monitor chk_u (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .run_stop_bit(run_stop_bit),
  .halted_status_bit(halted_status_bit),
  .internal_error_flag(internal_error_flag),
  .slave_error_flag(slave_error_flag),
  .decode_error_flag(decode_error_flag),
  .sg_internal_error(sg_internal_error), .mem_cmd_valid(mem_cmd_valid),
  .mem_cmd_ready(mem_cmd_ready), .mem_cmd(mem_cmd), .m_tvalid(m_tvalid),
  .m_tready(m_tready), .m_beat(m_beat), .ctrl_tdata(ctrl_tdata),
  .ctrl_tvalid(ctrl_tvalid), .ctrl_tlast(ctrl_tlast),
  .ctrl_tready(ctrl_tready), .stream_to_mem_channel_ptr_word(stream_to_mem_channel_ptr_word),
  .stream_to_mem_channel_next_desc(stream_to_mem_channel_next_desc)
);

// File: tb/sgds_mem_model.sv
// System memory model answering the engine's word requests
`timescale 1ns/1ps
module sgds_mem_model
  import sgds_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic mem_cmd_valid,
  output logic mem_cmd_ready,
  input wire sgds_mem_cmd_type mem_cmd,
  output logic mem_rsp_valid,
  output sgds_mem_rsp_type mem_rsp,
  input wire logic [31:0] err_addr,
  input wire logic [1:0] err_code,
  output logic [7:0] app_rd
);
  logic [31:0] mem [logic [31:0]];
  sgds_mem_cmd_type cmd_reg;
  logic pend;
  logic [1:0] wait_cnt;
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys)
  begin
    mem_rsp_valid <= 1'b0;
    // Idle response lines flip so a stale value never passes as fresh
    mem_rsp <= ~mem_rsp;
    // Ready one cycle late, so every request sees a stall first
    mem_cmd_ready <= mem_cmd_valid && !mem_cmd_ready && !pend;
    wait_cnt <= wait_cnt - 2'h1;
    if (sys_rst)
    begin
      pend <= 1'b0;
      app_rd <= 8'h00;
      mem_cmd_ready <= 1'b0;
      mem_rsp <= '0;
    end
    else if (mem_cmd_valid && mem_cmd_ready)
    begin
      cmd_reg <= mem_cmd;
      pend <= 1'b1;
      // Latency varies with the address, from one to four cycles
      wait_cnt <= mem_cmd.addr[3:2];
      if (!mem_cmd.write && mem_cmd.addr[5:2] >= 4'h8)
        app_rd <= app_rd + 8'h01;
    end
    else if (pend && wait_cnt == 2'h0)
    begin
      pend <= 1'b0;
      mem_rsp_valid <= 1'b1;
      mem_rsp.resp <= (cmd_reg.addr == err_addr) ? err_code : RESP_OKAY;
      if (cmd_reg.write)
        mem[cmd_reg.addr] = cmd_reg.wdata;
      else
        mem_rsp.rdata <= mem.exists(cmd_reg.addr) ? mem[cmd_reg.addr] : '0;
    end
  end
endmodule

// File: tb/tb_top.sv
// Testbench of the descriptor engine
`timescale 1ns/1ps
module tb_top;
  import sgds_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic run_start = 1'b0, ctrl_stream_option = 1'b0, tail_kick = 1'b0;
  logic m_tready = 1'b0, ctrl_tready = 1'b0;
  logic [31:0] first_desc_ptr = '0, tail_desc_ptr = '0;
  logic [31:0] stream_to_mem_channel_ptr_word = '0, stream_to_mem_channel_next_desc, ctrl_tdata;
  logic [31:0] err_addr = 32'hffff_fff0;
  logic [1:0] err_code = RESP_OKAY;
  logic run_stop_bit, halted_status_bit, idle, ctrl_tvalid, ctrl_tlast;
  logic internal_error_flag, slave_error_flag, decode_error_flag;
  logic sg_internal_error, mem_cmd_valid, mem_cmd_ready, mem_rsp_valid;
  logic m_tvalid;
  logic [7:0] app_rd;
  sgds_mem_cmd_type mem_cmd;
  sgds_mem_rsp_type mem_rsp;
  sgds_beat_type m_beat;
  logic [31:0] ctrl_q[$];
  sgds_beat_type beat_q[$];
  int error_cnt = 0, n_checks = 0, cyc = 0;

  always #4 clk_sys = ~clk_sys;

  sgds_engine dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .run_start(run_start), .tail_kick(tail_kick),
    .first_desc_ptr(first_desc_ptr), .tail_desc_ptr(tail_desc_ptr),
    .ctrl_stream_option(ctrl_stream_option), .run_stop_bit(run_stop_bit),
    .halted_status_bit(halted_status_bit), .idle(idle),
    .internal_error_flag(internal_error_flag),
    .slave_error_flag(slave_error_flag),
    .decode_error_flag(decode_error_flag),
    .sg_internal_error(sg_internal_error), .mem_cmd_valid(mem_cmd_valid),
    .mem_cmd_ready(mem_cmd_ready), .mem_cmd(mem_cmd),
    .mem_rsp_valid(mem_rsp_valid), .mem_rsp(mem_rsp),
    .m_tvalid(m_tvalid), .m_tready(m_tready), .m_beat(m_beat),
    .ctrl_tdata(ctrl_tdata), .ctrl_tvalid(ctrl_tvalid),
    .ctrl_tlast(ctrl_tlast), .ctrl_tready(ctrl_tready),
    .stream_to_mem_channel_ptr_word(stream_to_mem_channel_ptr_word), .stream_to_mem_channel_next_desc(stream_to_mem_channel_next_desc));

  sgds_mem_model mem_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .mem_cmd_valid(mem_cmd_valid), .mem_cmd_ready(mem_cmd_ready),
    .mem_cmd(mem_cmd), .mem_rsp_valid(mem_rsp_valid), .mem_rsp(mem_rsp),
    .err_addr(err_addr), .err_code(err_code), .app_rd(app_rd));
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (ctrl_tvalid && ctrl_tready)
      ctrl_q.push_back(ctrl_tdata);
    if (m_tvalid && m_tready)
      beat_q.push_back(m_beat);
    if (cyc == 30000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  // Both streams stall in a fixed pattern to exercise the hold rules
  always @(negedge clk_sys)
  begin
    m_tready <= cyc[0];
    ctrl_tready <= cyc[1] | cyc[0];
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic put_desc(input logic [31:0] a, bf, ct, st);
    mem_u.mem[a] = a;
    mem_u.mem[a + 32'h08] = bf;
    mem_u.mem[a + 32'h18] = ct;
    mem_u.mem[a + 32'h1c] = st;
    for (int i = 0; i < 5; i++)
      mem_u.mem[a + 32'h20 + 32'(4 * i)] = 32'ha0 + 32'(i);
  endtask

  // Descriptor is its own tail, so the engine stops after it
  task automatic run(input logic [31:0] a, input logic opt);
    ctrl_q.delete();
    beat_q.delete();
    @(negedge clk_sys);
    first_desc_ptr = a;
    tail_desc_ptr = a;
    ctrl_stream_option = opt;
    run_start = 1'b1;
    @(negedge clk_sys);
    run_start = 1'b0;
    repeat (3000)
    begin
      @(negedge clk_sys);
      if (idle || halted_status_bit)
        break;
    end
    repeat (12) @(negedge clk_sys);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_good;
    put_desc(32'h100, 32'h1000, 32'h0c00_0006, 32'h0);
    mem_u.mem[32'h1000] = 32'h1122_3344;
    mem_u.mem[32'h1004] = 32'h5566_7788;
    run(32'h100, 1'b1);
    chk(mem_u.mem[32'h11c], 32'h8000_0006);
    chk(32'(ctrl_q.size()), 32'h5);
    for (int i = 0; i < 5; i++)
      chk(ctrl_q[i], 32'ha0 + 32'(i));
    chk(32'(beat_q.size()), 32'h2);
    chk(beat_q[0].data, 32'h1122_3344);
    chk(beat_q[1].data, 32'h5566_7788);
    chk({beat_q[1].keep, beat_q[1].last}, 5'h07);
    chk({run_stop_bit, halted_status_bit, idle}, 3'h5);
    chk({internal_error_flag, slave_error_flag}, 2'h0);
    chk({decode_error_flag, sg_internal_error}, 2'h0);
  endtask

  task automatic t_app;
    logic [7:0] n;
    n = app_rd;
    put_desc(32'h140, 32'h1000, 32'h0400_0004, 32'h0);
    run(32'h140, 1'b1);
    chk(app_rd - n, 8'h05);
    chk(32'(ctrl_q.size()), 32'h0);
    put_desc(32'h140, 32'h1000, 32'h0400_0004, 32'h0);
    run(32'h140, 1'b0);
    chk(app_rd - n, 8'h05);
    chk(mem_u.mem[32'h15c], 32'h8000_0004);
    // Recycled descriptor is resumed by a tail kick from idle
    put_desc(32'h140, 32'h1000, 32'h0400_0005, 32'h0);
    @(negedge clk_sys);
    tail_kick = 1'b1;
    @(negedge clk_sys);
    tail_kick = 1'b0;
    repeat (300) @(negedge clk_sys);
    chk(mem_u.mem[32'h15c], 32'h8000_0005);
  endtask

  // Zero length, slave error and decode error in turn
  task automatic t_err;
    logic [3:0] top;
    for (int k = 0; k < 3; k++)
    begin
      top = 4'h1 << k;
      put_desc(32'h200, 32'h2000, (k == 0) ? 32'h0c00_0000 : 32'h0c00_0004,
        32'h0);
      err_addr = (k == 0) ? 32'hffff_fff0 : 32'h2000;
      err_code = (k == 1) ? RESP_SLVERR : RESP_DECERR;
      run(32'h200, 1'b0);
      chk(mem_u.mem[32'h21c][31:28], top);
      chk({decode_error_flag, slave_error_flag, internal_error_flag},
        top[2:0]);
      chk({run_stop_bit, halted_status_bit}, 2'h1);
    end
    err_addr = 32'hffff_fff0;
  endtask

  task automatic t_stale;
    put_desc(32'h240, 32'h1000, 32'h0c00_0004, 32'h8000_0000);
    run(32'h240, 1'b0);
    chk(sg_internal_error, 1'b1);
    chk({run_stop_bit, halted_status_bit}, 2'h1);
    chk(mem_u.mem[32'h25c], 32'h8000_0000);
    chk(32'(beat_q.size()), 32'h0);
  endtask

  task automatic t_ptr;
    logic [31:0] v [2];
    v = '{32'h1234_5678, 32'hffff_ffff};
    foreach (v[i])
    begin
      @(negedge clk_sys);
      stream_to_mem_channel_ptr_word = v[i];
      @(negedge clk_sys);
      chk(stream_to_mem_channel_next_desc, v[i] & 32'hffff_ffc0);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_good();
    t_app();
    t_err();
    t_stale();
    t_ptr();
    t_good();
    end_of_test();
  end
endmodule
